// ### logic/swdt_params.svh
/*
  Constants of the system watchdog timer: port addresses, keys, register
  offsets, field positions, reset values and tick timing.
  Assumes a 40 MHz system clock.
*/
`ifndef SWDT_PARAMS_SVH
`define SWDT_PARAMS_SVH

`define SWDT_IDX_PORT      16'h004e
`define SWDT_DAT_PORT      16'h004f
`define SWDT_KEY_ENTER     8'h87
`define SWDT_KEY_EXIT      8'haa
`define SWDT_REG_LDSEL     8'h07
`define SWDT_REG_ACT       8'h30
`define SWDT_REG_UNIT      8'hf0
`define SWDT_REG_COUNT     8'hf1
`define SWDT_REG_RLD       8'hf2
`define SWDT_LDN_WDT       8'h08
`define SWDT_ACT_BIT       0
`define SWDT_UNIT_BIT      2
`define SWDT_KBD_BIT       6
`define SWDT_RST_LDSEL     8'h00
`define SWDT_RST_ACT       8'h00
`define SWDT_RST_UNIT      8'h00
`define SWDT_RST_COUNT     8'h00
`define SWDT_RST_RLD       8'h00
`define SWDT_CLK_HZ        40000000
`define SWDT_SEC_PER_MIN   60
`define SWDT_CYC_PER_SEC   (`SWDT_CLK_HZ * 1)

`endif

// ### logic/swdt_pkg.sv
/*
  Types of the system watchdog timer.
  Assumes the constants header is included by the design file.
*/
package swdt_pkg;
  typedef enum logic [1:0] {
    SWDT_CFG_LOCKED,
    SWDT_CFG_HALF,
    SWDT_CFG_OPEN
  } swdt_cfg_t;
endpackage

// ### logic/swdt_top.sv
/*
  System watchdog timer behind an index/data I/O port pair.
  Assumes single-cycle I/O read and write strobes synchronous to clk;
  kbd_irq is a level or pulse from the keyboard controller, synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swdt_params.svh"

// What this block does
// - Countdown expiry while running asserts the system reset output.
// - Timeout is an 8-bit tick count, valid range 1 to 255.
// - Unit bit 2 (0x04) clear means one-second ticks, set means one-minute ticks.
// - A reload restores the last programmed timeout without stopping.
// - Writing a nonzero timeout loads the counter and, with 0x30 bit 0 set, starts counting.
// - Writing zero timeout stops the countdown; no reset occurs unless the write coincides with the final tick.
// - Index port selects register, data port 0x4F reads or writes it.
// - With 0xF2 bit 0x40 set, keyboard activity reloads the countdown.
module swdt_top
  import swdt_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = `SWDT_CYC_PER_SEC
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic        kbd_irq,
  input  wire logic        reload_req,
  output logic             sys_rst_out,
  output logic             wdt_running
);

  swdt_cfg_t   cfg_ff;
  logic [7:0]  index_ff;
  logic [7:0]  ldsel_ff;
  logic [7:0]  act_ff;
  logic [7:0]  unit_ff;
  logic [7:0]  count_ff;
  logic [7:0]  rld_ff;
  logic [7:0]  ticks_ff;
  logic [31:0] pre_ff;
  logic [5:0]  min_ff;
  logic        run_ff;
  logic        rst_out_ff;
  logic [7:0]  rdata_ff;

  function automatic logic is_reg(input logic [7:0] idx,
                                  input logic [7:0] off);
    is_reg = (idx == off);
  endfunction

  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic open_cfg;
  logic wdt_sel;
  logic cnt_wr;
  logic reload;
  logic sec_tick;
  logic tick;
  logic dev_on;

  assign idx_wr   = io_wr && (io_addr == `SWDT_IDX_PORT);
  assign open_cfg = (cfg_ff == SWDT_CFG_OPEN);
  assign dat_wr   = io_wr && (io_addr == `SWDT_DAT_PORT) && open_cfg;
  assign dat_rd   = io_rd && (io_addr == `SWDT_DAT_PORT) && open_cfg;
  assign wdt_sel  = (ldsel_ff == `SWDT_LDN_WDT);
  assign dev_on   = act_ff[`SWDT_ACT_BIT];
  assign cnt_wr   = dat_wr && wdt_sel && is_reg(index_ff, `SWDT_REG_COUNT);
  assign reload   = run_ff && (reload_req
                    || (kbd_irq && rld_ff[`SWDT_KBD_BIT]));
  assign sec_tick = (pre_ff == CYC_PER_SEC - 1);
  assign tick     = sec_tick && (!unit_ff[`SWDT_UNIT_BIT]
                    || (min_ff == 6'(`SWDT_SEC_PER_MIN - 1)));

  // Key sequence: two consecutive entry keys open, exit key closes.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_ff <= SWDT_CFG_LOCKED;
    else if (idx_wr)
    begin
      case (cfg_ff)
        SWDT_CFG_LOCKED:
          cfg_ff <= (io_wdata == `SWDT_KEY_ENTER) ? SWDT_CFG_HALF
                                                 : SWDT_CFG_LOCKED;
        SWDT_CFG_HALF:
          cfg_ff <= (io_wdata == `SWDT_KEY_ENTER) ? SWDT_CFG_OPEN
                                                 : SWDT_CFG_LOCKED;
        SWDT_CFG_OPEN:
          if (io_wdata == `SWDT_KEY_EXIT)
            cfg_ff <= SWDT_CFG_LOCKED;
        default:
          cfg_ff <= SWDT_CFG_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      index_ff <= 8'h00;
    else if (idx_wr && open_cfg)
      index_ff <= io_wdata;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ldsel_ff <= `SWDT_RST_LDSEL;
      act_ff   <= `SWDT_RST_ACT;
      unit_ff  <= `SWDT_RST_UNIT;
      count_ff <= `SWDT_RST_COUNT;
      rld_ff   <= `SWDT_RST_RLD;
    end
    else if (dat_wr)
    begin
      if (is_reg(index_ff, `SWDT_REG_LDSEL))
        ldsel_ff <= io_wdata;
      if (wdt_sel && is_reg(index_ff, `SWDT_REG_ACT))
        act_ff <= io_wdata;
      if (wdt_sel && is_reg(index_ff, `SWDT_REG_UNIT))
        unit_ff <= io_wdata;
      if (cnt_wr)
        count_ff <= io_wdata;
      if (wdt_sel && is_reg(index_ff, `SWDT_REG_RLD))
        rld_ff <= io_wdata;
    end
  end

  // Reads: unmapped or unselected registers return zero.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= 8'h00;
    else if (dat_rd)
    begin
      if (is_reg(index_ff, `SWDT_REG_LDSEL))
        rdata_ff <= ldsel_ff;
      else if (!wdt_sel)
        rdata_ff <= 8'h00;
      else if (is_reg(index_ff, `SWDT_REG_ACT))
        rdata_ff <= act_ff;
      else if (is_reg(index_ff, `SWDT_REG_UNIT))
        rdata_ff <= unit_ff;
      else if (is_reg(index_ff, `SWDT_REG_COUNT))
        rdata_ff <= ticks_ff;
      else if (is_reg(index_ff, `SWDT_REG_RLD))
        rdata_ff <= rld_ff;
      else
        rdata_ff <= 8'h00;
    end
  end

  // Prescaler restarts on every load or reload so a full tick elapses.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_ff <= 32'h0;
      min_ff <= 6'h00;
    end
    else if (!run_ff || cnt_wr || reload)
    begin
      pre_ff <= 32'h0;
      min_ff <= 6'h00;
    end
    else if (sec_tick)
    begin
      pre_ff <= 32'h0;
      min_ff <= tick ? 6'h00 : min_ff + 6'h01;
    end
    else
      pre_ff <= pre_ff + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ticks_ff <= 8'h00;
      run_ff   <= 1'b0;
    end
    else if (cnt_wr)
    begin
      ticks_ff <= io_wdata;
      run_ff   <= (io_wdata != 8'h00) && dev_on;
    end
    else if (!dev_on)
      run_ff <= 1'b0;
    else if (reload)
      ticks_ff <= count_ff;
    else if (run_ff && tick)
    begin
      ticks_ff <= ticks_ff - 8'h01;
      if (ticks_ff == 8'h01)
        run_ff <= 1'b0;
    end
  end

  // Reset output is sticky until the host rewrites the timeout.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_out_ff <= 1'b0;
    else if (run_ff && dev_on && tick && ticks_ff == 8'h01 && !reload)
      rst_out_ff <= 1'b1;
    else if (cnt_wr)
      rst_out_ff <= 1'b0;
  end

  assign io_rdata    = rdata_ff;
  assign sys_rst_out = rst_out_ff;
  assign wdt_running = run_ff;

  property p_expire;
    @(posedge clk) disable iff (!rst_b)
    (run_ff && tick && ticks_ff == 8'h01 && !reload && !cnt_wr && dev_on)
      |=> sys_rst_out && !wdt_running;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry did not raise system reset");

  property p_zero_stop;
    @(posedge clk) disable iff (!rst_b)
    (cnt_wr && io_wdata == 8'h00) |=> !wdt_running;
  endproperty
  a_zero_stop: assert property (p_zero_stop)
    else $error("zero timeout did not stop the timer");

  property p_start;
    @(posedge clk) disable iff (!rst_b)
    (cnt_wr && io_wdata != 8'h00 && dev_on)
      |=> wdt_running && ticks_ff == $past(io_wdata);
  endproperty
  a_start: assert property (p_start)
    else $error("nonzero timeout did not start the timer");

  property p_reload;
    @(posedge clk) disable iff (!rst_b)
    (reload && !cnt_wr && dev_on) |=> ticks_ff == $past(count_ff)
      && wdt_running;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not restore timeout");

  property p_disable;
    @(posedge clk) disable iff (!rst_b)
    (!dev_on && !cnt_wr) |=> !wdt_running;
  endproperty
  a_disable: assert property (p_disable)
    else $error("inactive device kept running");

  property p_locked;
    @(posedge clk) disable iff (!rst_b)
    (cfg_ff == SWDT_CFG_LOCKED) |=> $stable(count_ff) && $stable(ldsel_ff);
  endproperty
  a_locked: assert property (p_locked)
    else $error("register changed while configuration locked");

  property p_exit;
    @(posedge clk) disable iff (!rst_b)
    (open_cfg && idx_wr && io_wdata == `SWDT_KEY_EXIT)
      |=> cfg_ff == SWDT_CFG_LOCKED;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit key did not lock configuration");

  property p_unit_sec;
    @(posedge clk) disable iff (!rst_b)
    (run_ff && sec_tick && !unit_ff[`SWDT_UNIT_BIT] && !reload && !cnt_wr
      && dev_on && ticks_ff > 8'h01) |=> ticks_ff == $past(ticks_ff) - 8'h01;
  endproperty
  a_unit_sec: assert property (p_unit_sec)
    else $error("second tick did not decrement count");

endmodule
`default_nettype wire

// ### verif/swdt_host_model.sv
/*
  Host software model: index/data port cycles and config key sequences.
  Assumes the device samples strobes on rising clk edges.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swdt_params.svh"
module swdt_host_model
(
  input  wire logic        clk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata
);
  initial
  begin
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // Released address and data lines are inverted so stale values never look valid.
  task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                     input logic r);
    @(posedge clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = ~r;
    io_rd    = r;
    @(posedge clk);
    #1;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = ~d;
    io_addr  = ~a;
  endtask
  task automatic enter();
    cyc(`SWDT_IDX_PORT, `SWDT_KEY_ENTER, 1'b0);
    cyc(`SWDT_IDX_PORT, `SWDT_KEY_ENTER, 1'b0);
  endtask
  task automatic leave();
    cyc(`SWDT_IDX_PORT, `SWDT_KEY_EXIT, 1'b0);
  endtask
  task automatic wreg(input logic [7:0] off, input logic [7:0] d);
    cyc(`SWDT_IDX_PORT, off, 1'b0);
    cyc(`SWDT_DAT_PORT, d, 1'b0);
  endtask
  task automatic rreg(input logic [7:0] off);
    cyc(`SWDT_IDX_PORT, off, 1'b0);
    cyc(`SWDT_DAT_PORT, 8'h00, 1'b1);
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench of the watchdog; reads are checked from a queue.
  Assumes a tick of four clocks set through CYC_PER_SEC.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam int CPS = 4;
  logic        clk;
  logic        rst_b;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        kbd_irq;
  logic        reload_req;
  logic        sys_rst_out;
  logic        wdt_running;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_v;
  logic        rd_pend;
  int          num_errors;
  int          total_checks;
  int          n;
  swdt_top #(.CYC_PER_SEC(CPS)) uut (.clk(clk), .rst_b(rst_b),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .kbd_irq(kbd_irq),
    .reload_req(reload_req), .sys_rst_out(sys_rst_out),
    .wdt_running(wdt_running));
  swdt_host_model u_host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rreg(off);
  endtask
  task automatic pulse(input bit kbd);
    @(posedge clk);
    #1;
    if (kbd)
      kbd_irq = 1'b1;
    else
      reload_req = 1'b1;
    @(posedge clk);
    #1;
    kbd_irq    = 1'b0;
    reload_req = 1'b0;
  endtask
  task automatic st(input logic r, input logic run);
    `CHK(sys_rst_out, r)
    `CHK(wdt_running, run)
  endtask
  always @(posedge clk)
  begin
    if (rd_pend && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK(io_rdata, exp_v)
    end
    rd_pend = io_rd;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial
  begin
    num_errors = 0;
    total_checks = 0;
    rd_pend = 1'b0;
    rst_b = 1'b0;
    kbd_irq = 1'b0;
    reload_req = 1'b0;
    void'($urandom(83));
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    u_host.wreg(8'h07, 8'h08);
    u_host.enter();
    rd(8'h07, 8'h00);
    u_host.wreg(8'h07, 8'h08);
    u_host.wreg(8'h30, 8'h01);
    rd(8'h30, 8'h01);
    n = $urandom % 6 + 2;
    u_host.wreg(8'hf1, n[7:0]);
    wc(n * CPS - 4);
    st(1'b0, 1'b1);
    wc(7);
    st(1'b1, 1'b0);
    u_host.wreg(8'hf1, 8'h04);
    u_host.wreg(8'hf1, 8'h00);
    wc(40);
    st(1'b0, 1'b0);
    u_host.wreg(8'hf1, 8'h04);
    wc(10);
    pulse(1'b0);
    wc(10);
    st(1'b0, 1'b1);
    wc(16);
    st(1'b1, 1'b0);
    u_host.wreg(8'hf2, 8'h40);
    u_host.wreg(8'hf1, 8'h04);
    repeat (4)
    begin
      wc(10);
      pulse(1'b1);
    end
    st(1'b0, 1'b1);
    rd(8'hf2, 8'h40);
    u_host.wreg(8'h07, 8'h01);
    rd(8'hf2, 8'h00);
    u_host.wreg(8'h07, 8'h08);
    u_host.wreg(8'hf2, 8'h00);
    u_host.wreg(8'hf1, 8'h04);
    wc(6);
    pulse(1'b1);
    wc(10);
    st(1'b1, 1'b0);
    u_host.wreg(8'hf0, 8'h04);
    rd(8'hf0, 8'h04);
    u_host.wreg(8'hf1, 8'h01);
    wc(60 * CPS - 12);
    st(1'b0, 1'b1);
    wc(20);
    st(1'b1, 1'b0);
    u_host.wreg(8'hf1, 8'h03);
    u_host.wreg(8'h30, 8'h00);
    wc(2);
    st(1'b0, 1'b0);
    u_host.leave();
    u_host.wreg(8'h30, 8'h01);
    u_host.enter();
    u_host.wreg(8'h07, 8'h08);
    rd(8'h30, 8'h00);
    wc(4);
    end_sim();
  end
endmodule
`default_nettype wire
